// file: rtl/tscr_regs.sv
// Status and configuration register bank of a dual-bus terminal.
// Assumes protocol engine events arrive on clk_sys; address pins are asynchronous.
//
// What this block does
// - Transmit self-test word on request; host readable
// - Transmitter overrun sets self-test bit 15
// - Per-bus loopback failure bits 14 and 13
// - Shutdown command disables other bus transmitter
// - Word count high and low flags
// - Receiving RT-RT gap/sync/format/address error flag
// - RT-RT response timeout from selected limit
// - Receiving RT-RT transmit command word error
// - Config six top bit enables enhanced controller
// - Fast host access shortens host wait
// - Late increment moves stack step to end
// - Global ring enable and size decode
// - Event queue enable and suppression bits
// - Terminal address from pins or config five
// - Enhanced monitor stores all words in combined RT/MT mode
// - Clock select field decodes input frequency
// - Offline on initiate self-test command
// - Sync data loads time tag, gated
// - Frame timer end flag and maskable interrupt
// - Memory management bit zero selects shared output
// - Condition codes hold retries and message result
// - Host set/clear flags; compare results use flags
`timescale 1ns/1ps
`default_nettype none

module tscr_regs import tscr_pkg::*; #(
	parameter int TX_TIMEOUT = TX_TIMEOUT_CYC,
	parameter int RTRT_TO2 = RTRT_TO2_CYC,
	parameter int RTRT_TO3 = RTRT_TO3_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Host bus
	input wire logic host_cs,
	input wire logic host_we,
	input wire logic [4:0] host_addr,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata,
	output logic host_ready,
	// Protocol engine side
	input wire tscr_evt_t evt,
	input wire tscr_result_t msg_result,
	input wire logic [15:0] sync_data_word,
	input wire logic msg_busy,
	input wire logic mode_rt_or_mt,
	input wire logic mode_rt_mt_combined,
	input wire logic bitword_req,
	output logic [15:0] bitword_tx_data,
	output logic bitword_tx_valid,
	// Fields held in neighbouring registers
	input wire logic [1:0] cfg5_rtrt_timeout_sel,
	input wire logic [5:0] cfg5_addr_parity,
	input wire logic cfg5_sync_data_en,
	input wire logic int_mask_frame,
	// Pins
	input wire logic [5:0] rt_addr_pins,
	input wire logic in_command_src,
	input wire logic mode_code_reset_src,
	output logic shared_status_pin,
	// Controls to the engines
	output logic enhanced_controller_mode,
	output logic fast_host_access,
	output logic tx_disable_a,
	output logic tx_disable_b,
	output logic [15:0] cmd_stack_ptr,
	output logic global_ring_active,
	output logic [13:0] global_ring_words,
	output logic queue_push,
	output logic [5:0] terminal_address,
	output logic monitor_store_all,
	output logic [4:0] clock_frequency_mhz,
	output logic terminal_offline,
	output logic [15:0] time_tag,
	output logic end_of_frame_flag,
	output logic frame_irq
);

	tscr_state_t s, n;

	// ----------------------------------------
	// Decoders
	// ----------------------------------------
	function automatic logic [13:0] ring_words(input logic en, input logic [2:0] sz);
		ring_words = (en && sz != 3'h0) ? (RING_BASE_WORDS << sz) : 14'h0000;
	endfunction

	function automatic logic [13:0] rtrt_limit(input logic [1:0] sel);
		case (sel)
			2'h0: rtrt_limit = 14'(RTRT_TO0_CYC);
			2'h1: rtrt_limit = 14'(RTRT_TO1_CYC);
			2'h2: rtrt_limit = 14'(RTRT_TO2);
			default: rtrt_limit = 14'(RTRT_TO3);
		endcase
	endfunction

	logic [15:0] ccode_word;
	logic go_ack, wr;
	logic [13:0] rt_lim;
	logic [7:0] set_b, clr_b;

	// Condition codes share the flag bits and mirror the enhanced mode bit
	assign ccode_word = {s.cfg6[C6_ENH_BC], s.ccode, s.gpf};
	assign rt_lim = rtrt_limit(cfg5_rtrt_timeout_sel);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = s;
		n.bit_tx_valid = 1'b0;
		n.eof = 1'b0;
		n.frame_irq = 1'b0;
		n.queue_push = 1'b0;
		n.addr_s1 = rt_addr_pins;
		n.addr_s2 = s.addr_s1;
		set_b = 8'h00;
		clr_b = 8'h00;

		case (s.hst)
			HS_IDLE: begin
				if (host_cs) begin
					n.wait_cnt = 3'h0;
					n.hst = msg_busy ? HS_WAIT : HS_ACK;
				end
			end
			HS_WAIT: begin
				if (!msg_busy) begin
					n.hst = HS_ACK;
				end else if (s.cfg6[C6_FAST_HOST]) begin
					if (s.wait_cnt == FAST_WAIT_CYC - 3'h1) begin
						n.hst = HS_ACK;
					end else begin
						n.wait_cnt = s.wait_cnt + 3'h1;
					end
				end
			end
			HS_ACK: n.hst = HS_IDLE;
			default: n.hst = HS_IDLE;
		endcase
		go_ack = (n.hst == HS_ACK) && (s.hst != HS_ACK);
		wr = (s.hst == HS_ACK) && host_we;

		// read mux, captured as the grant is made
		if (go_ack && !host_we) begin
			case (host_addr)
				ADDR_SELFTEST_ERR: n.rdata = s.bitword;
				ADDR_CONFIG_SIX: n.rdata = s.cfg6;
				ADDR_MEM_MGMT: n.rdata = s.memcfg;
				ADDR_FLAGS: n.rdata = ccode_word;
				ADDR_SELFTEST_STAT: n.rdata = s.stat;
				default: n.rdata = RESET_WORD;
			endcase
		end

		if (wr && host_addr == ADDR_CONFIG_SIX) begin
			n.cfg6 = host_wdata;
		end
		if (wr && host_addr == ADDR_MEM_MGMT) begin
			n.memcfg = host_wdata;
		end

		// host flag set and clear bytes
		if (wr && host_addr == ADDR_FLAGS) begin
			set_b = host_wdata[7:0];
			clr_b = host_wdata[15:8];
		end
		// clear applied last so it wins
		n.gpf = (s.gpf | set_b) & ~clr_b;
		// compare results land in flags one and zero
		if (evt.cmp_valid) begin
			n.gpf[1] = evt.cmp_equal;
			n.gpf[0] = evt.cmp_less;
		end

		// self-test word sent to the controller
		if (bitword_req) begin
			n.bit_tx_data = s.bitword;
			n.bit_tx_valid = 1'b1;
		end

		// Message-scoped bits restart with each message; sets below win
		if (evt.msg_start) begin
			n.bitword[BW_WC_HIGH] = 1'b0;
			n.bitword[BW_WC_LOW] = 1'b0;
			n.bitword[BW_RTRT_ERR] = 1'b0;
			n.bitword[BW_RTRT_TO] = 1'b0;
			n.bitword[BW_RTRT_CWE] = 1'b0;
		end

		if (!evt.tx_active) begin
			n.tx_cnt = 17'h00000;
			n.tx_to_done = 1'b0;
		end else if (!s.tx_to_done) begin
			if (s.tx_cnt == 17'(TX_TIMEOUT - 1)) begin
				n.tx_to_done = 1'b1;
				n.bitword[BW_TX_TIMEOUT] = 1'b1;
			end else begin
				n.tx_cnt = s.tx_cnt + 17'h00001;
			end
		end

		if (evt.loop_fail_b) begin
			n.bitword[BW_LOOP_B] = 1'b1;
		end
		if (evt.loop_fail_a) begin
			n.bitword[BW_LOOP_A] = 1'b1;
		end
		if (evt.handshake_fail) begin
			n.bitword[BW_HANDSHAKE] = 1'b1;
		end

		// shutdown acts on the bus the command did not arrive on
		if (evt.shutdown_cmd_on_a) begin
			n.bitword[BW_SHUT_B] = 1'b1;
			n.tx_dis_b = 1'b1;
		end
		if (evt.shutdown_cmd_on_b) begin
			n.bitword[BW_SHUT_A] = 1'b1;
			n.tx_dis_a = 1'b1;
		end
		if (evt.flag_inhibit_cmd) begin
			n.bitword[BW_FLAG_INH] = 1'b1;
		end
		if (evt.bist_fail) begin
			n.bitword[BW_BIT_FAIL] = 1'b1;
		end

		if (evt.word_count_high) begin
			n.bitword[BW_WC_HIGH] = 1'b1;
		end
		if (evt.word_count_low) begin
			n.bitword[BW_WC_LOW] = 1'b1;
		end
		if (evt.sync_err) begin
			n.bitword[BW_SYNC_ERR] = 1'b1;
		end
		if (evt.invalid_word) begin
			n.bitword[BW_INV_WORD] = 1'b1;
		end
		if (evt.cmd_word_err) begin
			n.bitword[BW_CMD_ERR] = 1'b1;
		end

		if (evt.rtrt_receiver && (evt.rtrt_gap_err || evt.rtrt_sync_err ||
				evt.rtrt_format_err || evt.rtrt_addr_err)) begin
			n.bitword[BW_RTRT_ERR] = 1'b1;
		end
		if (evt.rtrt_receiver && evt.rtrt_cmdword_err) begin
			n.bitword[BW_RTRT_CWE] = 1'b1;
		end

		// response timer; a response in the last cycle still counts
		if (evt.rtrt_wait_start) begin
			n.rt_wait = 1'b1;
			n.rt_cnt = 14'h0000;
		end else if (s.rt_wait) begin
			if (evt.rtrt_resp_seen) begin
				n.rt_wait = 1'b0;
			end else if (s.rt_cnt == rt_lim - 14'h0001) begin
				n.rt_wait = 1'b0;
				n.bitword[BW_RTRT_TO] = 1'b1;
			end else begin
				n.rt_cnt = s.rt_cnt + 14'h0001;
			end
		end

		// command stack step at start or end of message
		if (mode_rt_or_mt && ((evt.msg_start && !s.cfg6[C6_LATE_INC]) ||
				(evt.msg_end && s.cfg6[C6_LATE_INC]))) begin
			n.stack_ptr = s.stack_ptr + STACK_STEP;
		end

		// result of the last message; two retries encode as 11
		if (evt.msg_end) begin
			n.ccode = {msg_result.retries[1] ? 2'b11 : {1'b0, msg_result.retries[0]},
				msg_result.failed, msg_result.rt_status, msg_result.clean,
				msg_result.format_err, msg_result.no_resp};
		end

		// queue updates gated by enable and suppression
		if (evt.queue_event && s.cfg6[C6_QUEUE_EN]) begin
			n.queue_push = evt.queue_event_valid ? !s.cfg6[C6_SUP_VAL] : !s.cfg6[C6_SUP_INV];
		end

		if (evt.selftest_cmd && s.memcfg[MM_OFFLINE]) begin
			n.offline = 1'b1;
		end else if (evt.bist_done) begin
			n.offline = 1'b0;
		end
		if (evt.bist_done) begin
			n.stat[ST_PROTO_DONE] = 1'b1;
		end

		// time tag load, odd words refused in enhanced mode
		if (evt.sync_data_cmd && mode_rt_or_mt && cfg5_sync_data_en &&
				(!s.memcfg[MM_ENH_TT] || !sync_data_word[0])) begin
			n.time_tag = sync_data_word;
		end

		// end of frame flag and maskable interrupt
		if (evt.frame_expired && s.memcfg[MM_FRAME_IRQ]) begin
			n.eof = 1'b1;
			n.frame_irq = !int_mask_frame;
		end

		n.pin_out = s.memcfg[MM_PIN_SEL] ? mode_code_reset_src : in_command_src;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign host_ready = (s.hst == HS_ACK);
	assign host_rdata = s.rdata;
	assign bitword_tx_data = s.bit_tx_data;
	assign bitword_tx_valid = s.bit_tx_valid;
	assign shared_status_pin = s.pin_out;
	assign enhanced_controller_mode = s.cfg6[C6_ENH_BC];
	assign fast_host_access = s.cfg6[C6_FAST_HOST];
	assign tx_disable_a = s.tx_dis_a;
	assign tx_disable_b = s.tx_dis_b;
	assign cmd_stack_ptr = s.stack_ptr;
	// ring size, zero code means off
	assign global_ring_words = ring_words(s.cfg6[C6_RING_EN], s.cfg6[C6_RING_SZ_LO +: 3]);
	assign global_ring_active = (global_ring_words != 14'h0000);
	assign queue_push = s.queue_push;
	assign terminal_address = s.cfg6[C6_ADDR_SRC] ? cfg5_addr_parity : s.addr_s2;
	assign monitor_store_all = mode_rt_mt_combined && s.cfg6[C6_ENH_MON];
	always_comb begin
		case (s.cfg6[C6_CLK_SEL_LO +: 2])
			2'h0: clock_frequency_mhz = 5'h10;
			2'h1: clock_frequency_mhz = 5'h0C;
			2'h2: clock_frequency_mhz = 5'h14;
			default: clock_frequency_mhz = 5'h0A;
		endcase
	end
	assign terminal_offline = s.offline;
	assign time_tag = s.time_tag;
	assign end_of_frame_flag = s.eof;
	assign frame_irq = s.frame_irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_bitword_reply: assert property (bitword_req |=> bitword_tx_valid &&
		bitword_tx_data == $past(s.bitword)) else $error("self-test word not sent");
	a_tx_overrun: assert property (evt.tx_active && !s.tx_to_done &&
		s.tx_cnt == 17'(TX_TIMEOUT - 1) |=> s.bitword[BW_TX_TIMEOUT]) else $error("overrun missed");
	a_loopback_bus: assert property (evt.loop_fail_b && !evt.loop_fail_a |=>
		s.bitword[BW_LOOP_B] && s.bitword[BW_LOOP_A] == $past(s.bitword[BW_LOOP_A]))
		else $error("loopback bit wrong");
	a_shutdown_other: assert property (evt.shutdown_cmd_on_a |=>
		tx_disable_b && s.bitword[BW_SHUT_B]) else $error("other bus not shut down");
	a_word_count: assert property (evt.word_count_low |=> s.bitword[BW_WC_LOW])
		else $error("low count flag missed");
	a_rtrt_fault: assert property (evt.rtrt_receiver && evt.rtrt_addr_err |=>
		s.bitword[BW_RTRT_ERR]) else $error("transfer error missed");
	a_rtrt_timeout: assert property (s.rt_wait && !evt.rtrt_wait_start &&
		!evt.rtrt_resp_seen && s.rt_cnt == rt_lim - 14'h0001 |=> s.bitword[BW_RTRT_TO] && !s.rt_wait)
		else $error("transfer timeout missed");
	a_cmdword_err: assert property (!evt.rtrt_receiver && !evt.msg_start |=>
		s.bitword[BW_RTRT_CWE] == $past(s.bitword[BW_RTRT_CWE])) else $error("stray word error");
	a_enh_write: assert property (wr && host_addr == ADDR_CONFIG_SIX |=>
		enhanced_controller_mode == $past(host_wdata[15])) else $error("enhanced bit not stored");
	a_host_hold: assert property (s.hst == HS_WAIT && msg_busy && !fast_host_access |=>
		!host_ready) else $error("host granted during message");
	a_late_step: assert property (mode_rt_or_mt && evt.msg_end && !evt.msg_start &&
		s.cfg6[C6_LATE_INC] |=> cmd_stack_ptr == $past(cmd_stack_ptr) + STACK_STEP)
		else $error("stack step missed");
	a_queue_gate: assert property (queue_push |-> $past(s.cfg6[C6_QUEUE_EN]))
		else $error("queue push while disabled");
	a_addr_pins: assert property (!s.cfg6[C6_ADDR_SRC] && !$past(rst) && !$past(rst, 2) |->
		terminal_address == $past(rt_addr_pins, 2))
		else $error("address source wrong");
	a_frame_mask: assert property (frame_irq |-> end_of_frame_flag && !$past(int_mask_frame))
		else $error("masked frame interrupt");
	a_clear_wins: assert property (wr && host_addr == ADDR_FLAGS && host_wdata[15] &&
		host_wdata[7] |=> !s.gpf[7]) else $error("clear did not win");

	c_host_wait: cover property (s.hst == HS_WAIT ##[1:8] host_ready);
	c_rtrt_timeout: cover property (s.rt_wait ##1 $rose(s.bitword[BW_RTRT_TO]));
	c_bitword_sent: cover property (bitword_tx_valid && bitword_tx_data != 16'h0000);

endmodule

`default_nettype wire

// file: rtl/tscr_pkg.sv
// Package for the terminal status and configuration register bank.
// Assumes a 100 MHz system clock and a 16-bit parallel host bus.
package tscr_pkg;

	// ----------------------------------------
	// Clock and times
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TX_TIMEOUT_NS = 668000;
	localparam int RTRT_TO0_NS = 18500;
	localparam int RTRT_TO1_NS = 22500;
	localparam int RTRT_TO2_NS = 50500;
	localparam int RTRT_TO3_NS = 130000;
	// Timeouts are limits to exceed, so round up
	localparam int TX_TIMEOUT_CYC = (TX_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RTRT_TO0_CYC = (RTRT_TO0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RTRT_TO1_CYC = (RTRT_TO1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RTRT_TO2_CYC = (RTRT_TO2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RTRT_TO3_CYC = (RTRT_TO3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] FAST_WAIT_CYC = 3'h4;

	// ----------------------------------------
	// Register offsets (16-bit word addresses)
	// ----------------------------------------
	localparam logic [4:0] ADDR_SELFTEST_ERR = 5'h0F;
	localparam logic [4:0] ADDR_CONFIG_SIX = 5'h18;
	localparam logic [4:0] ADDR_MEM_MGMT = 5'h1A;
	localparam logic [4:0] ADDR_FLAGS = 5'h1B;
	localparam logic [4:0] ADDR_SELFTEST_STAT = 5'h1C;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BW_TX_TIMEOUT = 15;
	localparam int BW_LOOP_B = 14;
	localparam int BW_LOOP_A = 13;
	localparam int BW_HANDSHAKE = 12;
	localparam int BW_SHUT_B = 11;
	localparam int BW_SHUT_A = 10;
	localparam int BW_FLAG_INH = 9;
	localparam int BW_BIT_FAIL = 8;
	localparam int BW_WC_HIGH = 7;
	localparam int BW_WC_LOW = 6;
	localparam int BW_SYNC_ERR = 5;
	localparam int BW_INV_WORD = 4;
	localparam int BW_RTRT_ERR = 3;
	localparam int BW_RTRT_TO = 2;
	localparam int BW_RTRT_CWE = 1;
	localparam int BW_CMD_ERR = 0;
	localparam int C6_ENH_BC = 15;
	localparam int C6_FAST_HOST = 14;
	localparam int C6_LATE_INC = 13;
	localparam int C6_RING_EN = 12;
	localparam int C6_RING_SZ_LO = 9;
	localparam int C6_SUP_INV = 8;
	localparam int C6_SUP_VAL = 7;
	localparam int C6_QUEUE_EN = 6;
	localparam int C6_ADDR_SRC = 5;
	localparam int C6_ENH_MON = 4;
	localparam int C6_CLK_SEL_LO = 0;
	localparam int MM_OFFLINE = 4;
	localparam int MM_ENH_TT = 2;
	localparam int MM_FRAME_IRQ = 1;
	localparam int MM_PIN_SEL = 0;
	localparam int ST_PROTO_DONE = 15;
	localparam int CC_RETRY_LO = 13;
	localparam int CC_FAILED = 12;
	localparam int CC_RT_STAT = 11;
	localparam int CC_CLEAN = 10;
	localparam int CC_FORMAT = 9;
	localparam int CC_NO_RESP = 8;
	localparam logic [15:0] STACK_STEP = 16'h0004;
	localparam logic [13:0] RING_BASE_WORDS = 14'h0040;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_WAIT = 2'b01,
		HS_ACK = 2'b10
	} tscr_hstate_t;

	// Protocol engine events, one-cycle pulses unless noted
	typedef struct packed {
		logic tx_active;          // level
		logic loop_fail_a;
		logic loop_fail_b;
		logic handshake_fail;
		logic shutdown_cmd_on_a;
		logic shutdown_cmd_on_b;
		logic flag_inhibit_cmd;
		logic bist_fail;
		logic bist_done;
		logic word_count_high;
		logic word_count_low;
		logic sync_err;
		logic invalid_word;
		logic cmd_word_err;
		logic rtrt_receiver;      // level
		logic rtrt_gap_err;
		logic rtrt_sync_err;
		logic rtrt_format_err;
		logic rtrt_addr_err;
		logic rtrt_cmdword_err;
		logic rtrt_wait_start;
		logic rtrt_resp_seen;
		logic msg_start;
		logic msg_end;
		logic selftest_cmd;
		logic sync_data_cmd;
		logic frame_expired;
		logic queue_event;
		logic queue_event_valid;  // qualifies queue_event
		logic cmp_valid;
		logic cmp_equal;
		logic cmp_less;
	} tscr_evt_t;

	// Result of the most recent controller message, taken at msg_end
	typedef struct packed {
		logic [1:0] retries;
		logic failed;
		logic rt_status;
		logic clean;
		logic format_err;
		logic no_resp;
	} tscr_result_t;

	typedef struct packed {
		tscr_hstate_t hst;
		logic [2:0] wait_cnt;
		logic [15:0] bitword;
		logic [15:0] cfg6;
		logic [15:0] memcfg;
		logic [6:0] ccode;
		logic [15:0] stat;
		logic [7:0] gpf;
		logic [16:0] tx_cnt;
		logic tx_to_done;
		logic [13:0] rt_cnt;
		logic rt_wait;
		logic [15:0] stack_ptr;
		logic [15:0] time_tag;
		logic [15:0] rdata;
		logic [15:0] bit_tx_data;
		logic bit_tx_valid;
		logic [5:0] addr_s1;
		logic [5:0] addr_s2;
		logic offline;
		logic tx_dis_a;
		logic tx_dis_b;
		logic eof;
		logic frame_irq;
		logic pin_out;
		logic queue_push;
	} tscr_state_t;

endpackage

// file: tb/tscr_host.sv
// Host processor model for the register bank: one word access at a time.
// Assumes each access is answered by a one-cycle ready, possibly after a wait.
`timescale 1ns/1ps
`default_nettype none

module tscr_host (
	// Clock
	input wire logic clk_sys,
	// Host bus
	output logic host_cs,
	output logic host_we,
	output logic [4:0] host_addr,
	output logic [15:0] host_wdata,
	input wire logic host_ready
);
	initial begin
		host_cs = 1'b0;
		host_we = 1'b0;
		host_addr = 5'h00;
		host_wdata = 16'h0000;
	end

	// Entered just after a rising edge; the request holds until ready is sampled
	task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d,
		output int waited);
		waited = 0;
		host_cs <= 1'b1;
		host_we <= w;
		host_addr <= a;
		host_wdata <= d;
		@(posedge clk_sys);
		while (host_ready !== 1'b1) begin
			waited++;
			@(posedge clk_sys);
		end
		// Released lines carry no stale value
		host_cs <= 1'b0;
		host_addr <= ~a;
		host_wdata <= ~d;
		@(posedge clk_sys);
	endtask
endmodule

`default_nettype wire

// file: tb/tscr_regs_bench.sv
// Self-checking bench for the terminal status and configuration register bank.
// Assumes the host model runs bus cycles; engine events and pins come from here.
`timescale 1ns/1ps
`default_nettype none

module tscr_regs_bench import tscr_pkg::*;;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic host_cs, host_we, host_ready, bitword_tx_valid, shared_status_pin;
	logic [4:0] host_addr, clock_frequency_mhz;
	logic [15:0] host_rdata, host_wdata, sync_data_word, bitword_tx_data, cmd_stack_ptr;
	logic [15:0] time_tag, d;
	tscr_evt_t evt, e;
	tscr_result_t msg_result;
	logic msg_busy, mode_rt_or_mt, mode_rt_mt_combined, bitword_req, cfg5_sync_data_en;
	logic int_mask_frame, in_command_src, mode_code_reset_src, tx_disable_a, tx_disable_b;
	logic [1:0] cfg5_rtrt_timeout_sel;
	logic [5:0] cfg5_addr_parity, rt_addr_pins, terminal_address;
	logic enhanced_controller_mode, fast_host_access, global_ring_active, queue_push;
	logic monitor_store_all, terminal_offline, end_of_frame_flag, frame_irq;
	logic [13:0] global_ring_words;
	logic [15:0] exp_rd[$], exp_bw[$];
	int n_mismatch = 0, num_checks = 0, cycles = 0, w;
	logic [4:0] mhz[4] = '{5'h10, 5'h0C, 5'h14, 5'h0A};
	logic [4:0] adr[6] = '{ADDR_SELFTEST_ERR, ADDR_CONFIG_SIX, ADDR_MEM_MGMT, ADDR_FLAGS,
		ADDR_SELFTEST_STAT, 5'h05};

	always #5 clk_sys = ~clk_sys;

	// Short counts so the timers expire within a few dozen cycles
	tscr_regs #(.TX_TIMEOUT(20), .RTRT_TO2(30), .RTRT_TO3(40)) i_dut (.clk_sys, .rst,
		.host_cs, .host_we, .host_addr, .host_wdata, .host_rdata, .host_ready, .evt,
		.msg_result, .sync_data_word, .msg_busy, .mode_rt_or_mt, .mode_rt_mt_combined,
		.bitword_req, .bitword_tx_data, .bitword_tx_valid, .cfg5_rtrt_timeout_sel,
		.cfg5_addr_parity, .cfg5_sync_data_en, .int_mask_frame, .rt_addr_pins,
		.in_command_src, .mode_code_reset_src, .shared_status_pin, .enhanced_controller_mode,
		.fast_host_access, .tx_disable_a, .tx_disable_b, .cmd_stack_ptr, .global_ring_active,
		.global_ring_words, .queue_push, .terminal_address, .monitor_store_all,
		.clock_frequency_mhz, .terminal_offline, .time_tag, .end_of_frame_flag, .frame_irq);

	tscr_host i_host (.clk_sys, .host_cs, .host_we, .host_addr, .host_wdata, .host_ready);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] x);
		exp_rd.push_back(x);
		i_host.access(1'b0, a, 16'h0000, w);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] x);
		i_host.access(1'b1, a, x, w);
	endtask

	// One-cycle event pulse; returns where the registered effect is visible
	task automatic fire;
		evt <= e;
		@(posedge clk_sys);
		e = '0;
		evt <= '0;
		@(posedge clk_sys);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Result monitor and hang guard
	// ----------------------------------------
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			summarize();
		end
		if (host_ready === 1'b1 && host_we === 1'b0) begin
			chk(host_rdata, exp_rd.size() > 0 ? exp_rd.pop_front() : 16'hXXXX);
		end
		if (bitword_tx_valid === 1'b1) begin
			chk(bitword_tx_data, exp_bw.size() > 0 ? exp_bw.pop_front() : 16'hXXXX);
		end
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		evt = '0;
		e = '0;
		msg_result = '0;
		sync_data_word = 16'h0000;
		msg_busy = 1'b0;
		mode_rt_or_mt = 1'b1;
		mode_rt_mt_combined = 1'b0;
		bitword_req = 1'b0;
		cfg5_rtrt_timeout_sel = 2'h2;
		cfg5_addr_parity = 6'h15;
		cfg5_sync_data_en = 1'b1;
		int_mask_frame = 1'b0;
		rt_addr_pins = 6'h2A;
		in_command_src = 1'b0;
		mode_code_reset_src = 1'b0;
		void'($urandom(20455));
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk(clock_frequency_mhz, 5'h10);
		wr(ADDR_SELFTEST_ERR, 16'hFFFF);
		foreach (adr[i]) rd(adr[i], 16'h0000);
		$display("test reset done");
		e.loop_fail_b = 1'b1;
		e.word_count_high = 1'b1;
		e.shutdown_cmd_on_a = 1'b1;
		fire();
		chk(tx_disable_b, 1'b1);
		chk(tx_disable_a, 1'b0);
		rd(ADDR_SELFTEST_ERR, 16'h4880);
		e.loop_fail_a = 1'b1;
		e.word_count_low = 1'b1;
		e.shutdown_cmd_on_b = 1'b1;
		e.rtrt_receiver = 1'b1;
		e.rtrt_addr_err = 1'b1;
		e.rtrt_cmdword_err = 1'b1;
		fire();
		chk(tx_disable_a, 1'b1);
		rd(ADDR_SELFTEST_ERR, 16'h6CCA);
		e.rtrt_wait_start = 1'b1;
		fire();
		repeat (20) @(posedge clk_sys);
		rd(ADDR_SELFTEST_ERR, 16'h6CCA);
		repeat (10) @(posedge clk_sys);
		rd(ADDR_SELFTEST_ERR, 16'h6CCE);
		evt.tx_active <= 1'b1;
		repeat (25) @(posedge clk_sys);
		evt.tx_active <= 1'b0;
		rd(ADDR_SELFTEST_ERR, 16'hECCE);
		exp_bw.push_back(16'hECCE);
		bitword_req <= 1'b1;
		@(posedge clk_sys);
		bitword_req <= 1'b0;
		e.msg_start = 1'b1;
		fire();
		chk(cmd_stack_ptr, 16'h0004);
		rd(ADDR_SELFTEST_ERR, 16'hEC00);
		e.rtrt_receiver = 1'b1;
		e.rtrt_gap_err = 1'b1;
		fire();
		rd(ADDR_SELFTEST_ERR, 16'hEC08);
		$display("test selftest word done");
		mode_rt_mt_combined <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			rt_addr_pins <= 6'($urandom);
			d = 16'($urandom);
			d[11:9] = k[2:0];
			wr(ADDR_CONFIG_SIX, d);
			rd(ADDR_CONFIG_SIX, d);
			chk(enhanced_controller_mode, d[15]);
			chk(fast_host_access, d[14]);
			chk(global_ring_active, d[12] && k > 0);
			chk(global_ring_words, (d[12] && k > 0) ? 14'h0040 << k : 14'h0000);
			chk(terminal_address, d[5] ? cfg5_addr_parity : rt_addr_pins);
			chk(monitor_store_all, d[4]);
			chk(clock_frequency_mhz, mhz[d[1:0]]);
		end
		$display("test config six done");
		wr(ADDR_CONFIG_SIX, 16'h4000);
		msg_busy <= 1'b1;
		rd(ADDR_CONFIG_SIX, 16'h4000);
		chk(16'(w <= 5), 16'h0001);
		wr(ADDR_CONFIG_SIX, 16'h2000);
		fork
			begin
				repeat (12) @(posedge clk_sys);
				msg_busy <= 1'b0;
			end
			rd(ADDR_CONFIG_SIX, 16'h2000);
		join
		chk(16'(w >= 12), 16'h0001);
		e.msg_start = 1'b1;
		fire();
		chk(cmd_stack_ptr, 16'h0004);
		e.msg_end = 1'b1;
		msg_result <= '{2'h2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		fire();
		chk(cmd_stack_ptr, 16'h0008);
		$display("test host wait done");
		wr(ADDR_FLAGS, 16'h00A5);
		rd(ADDR_FLAGS, 16'h73A5);
		wr(ADDR_FLAGS, 16'h8181);
		rd(ADDR_FLAGS, 16'h7324);
		e.cmp_valid = 1'b1;
		e.cmp_equal = 1'b1;
		fire();
		rd(ADDR_FLAGS, 16'h7326);
		wr(ADDR_FLAGS, 16'hFF00);
		rd(ADDR_FLAGS, 16'h7300);
		$display("test flags done");
		mode_code_reset_src <= 1'b1;
		wr(ADDR_MEM_MGMT, 16'h0017);
		rd(ADDR_MEM_MGMT, 16'h0017);
		chk(shared_status_pin, 1'b1);
		e.selftest_cmd = 1'b1;
		fire();
		chk(terminal_offline, 1'b1);
		e.bist_done = 1'b1;
		fire();
		rd(ADDR_SELFTEST_STAT, 16'h8000);
		sync_data_word <= 16'h1235;
		e.sync_data_cmd = 1'b1;
		fire();
		chk(time_tag, 16'h0000);
		sync_data_word <= 16'h1234;
		e.sync_data_cmd = 1'b1;
		fire();
		chk(time_tag, 16'h1234);
		// Pass 0 pushes; pass 1 drops a valid event, pass 2 an invalid one
		for (int m = 0; m < 3; m++) begin
			int_mask_frame <= m[0];
			wr(ADDR_CONFIG_SIX, m == 0 ? 16'h0040 : (m == 1 ? 16'h00C0 : 16'h0140));
			e.frame_expired = 1'b1;
			e.queue_event = 1'b1;
			e.queue_event_valid = (m != 2);
			fire();
			chk(end_of_frame_flag, 1'b1);
			chk(frame_irq, !m[0]);
			chk(queue_push, m == 0);
		end
		$display("test misc config done");
		summarize();
	end
endmodule

`default_nettype wire
